// [logic/qsc_pkg.sv]
// Package for the quad-rate static memory clocking and pin-transfer block.
// Assumes core_clk runs at four times the base rate, twice the double-rate pin clock.
package qsc_pkg;
  // ==========================================================
  // Widths
  localparam int ADDR_W = 18;
  localparam int DATA_W = 18;
  localparam int BWS_W  = 2;

  // ==========================================================
  // Reset values of the forwarded clock pair and selects
  localparam logic RST_TFF   = 1'h0;
  localparam logic RST_KTRUE = 1'h0;
  localparam logic RST_KCOMP = 1'h1;
  localparam logic SEL_IDLE  = 1'h1;
  localparam logic SEL_ACT   = 1'h0;

  // ==========================================================
  // Phases of one base cycle: even phases end on a rising 2x edge,
  // odd phases end on a falling 2x edge
  typedef enum logic [3:0] {
    QSC_PH0 = 4'h1,
    QSC_PH1 = 4'h2,
    QSC_PH2 = 4'h4,
    QSC_PH3 = 4'h8
  } qsc_phase_t;

  // ==========================================================
  // System-side request, one per base cycle
  typedef struct packed {
    logic              rdEn;
    logic              wrEn;
    logic [ADDR_W-1:0] rdAddr;
    logic [ADDR_W-1:0] wrAddr;
    logic [BWS_W-1:0]  byteEn;
    logic [DATA_W-1:0] wrWord0;
    logic [DATA_W-1:0] wrWord1;
  } qsc_req_t;

  // Pin bundle toward the memory
  typedef struct packed {
    logic              rdSelN;
    logic              wrSelN;
    logic [BWS_W-1:0]  byteSelN;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
  } qsc_pins_t;
endpackage

// [logic/qsc_clock_io.sv]
// Clocking and double-rate pin transfer for a quad-rate static memory.
// Assumes core_clk runs at twice the 2x rate, one cycle per 2x edge; the returned memory clock and read
// data arrive asynchronously and are sampled by core_clk.
// Function
// - Two related clocks are used: a base-rate 1x clock and a double-rate 2x clock.
// - System requests are taken on the 1x clock and piped through 1x stages.
// - Write data and address leave at double rate, two values per base cycle; selects change once per base cycle.
// - The forwarded pair comes from a toggle flip-flop on the 2x clock whose outputs are registered.
// - The forwarded pair is a base-rate clock and its 180 degree shifted complement.
// - Each forwarded clock output is driven by its own dedicated register.
// - Clock registers move on the rising 2x edge, data and address on the falling one.
// - Read data is sampled by core_clk at edges of the returned memory clock, found through synchronizer flops.
// - A word launched on the rising returned clock is taken on its next falling edge.
// - A word launched on the rising complement is taken on the next rising true edge.
// - Active-low port selects are driven by us and sampled on the true clock rise.
`timescale 1ns/100ps
module qsc_clock_io (
  input  wire logic                      core_clk,
  input  wire logic                      reset_n,
  input  wire logic                      clkEn,
  input  wire qsc_pkg::qsc_req_t         sysReq,
  output qsc_pkg::qsc_pins_t             memPins,
  output logic                           memK,
  output logic                           memKn,
  input  wire logic                      retClk,
  input  wire logic [qsc_pkg::DATA_W-1:0] memRdData,
  output logic [qsc_pkg::DATA_W-1:0]     rdWord0,
  output logic [qsc_pkg::DATA_W-1:0]     rdWord1,
  output logic                           rdValid
);
  // ==========================================================
  // State
  typedef struct packed {
    qsc_pkg::qsc_phase_t         phase;
    qsc_pkg::qsc_req_t           stage;
    logic                        tff;
    logic                        kTrue;
    logic                        kComp;
    qsc_pkg::qsc_pins_t          pins;
    logic                        cS1;
    logic                        cS2;
    logic                        cS3;
    logic [qsc_pkg::DATA_W-1:0]  dS1;
    logic [qsc_pkg::DATA_W-1:0]  dS2;
    logic [qsc_pkg::DATA_W-1:0]  loWord;
    logic [qsc_pkg::DATA_W-1:0]  word0;
    logic [qsc_pkg::DATA_W-1:0]  word1;
    logic                        valid;
  } qsc_state_t;

  qsc_state_t st;
  qsc_state_t next_st;

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.valid = 1'h0;
    // Returned clock and data pass two flops before use
    next_st.cS1 = retClk;
    next_st.cS2 = st.cS1;
    next_st.cS3 = st.cS2;
    next_st.dS1 = memRdData;
    next_st.dS2 = st.dS1;
    if (st.cS3 && !st.cS2) begin
      next_st.loWord = st.dS2;
    end
    if (!st.cS3 && st.cS2) begin
      next_st.word0 = st.loWord;
      next_st.word1 = st.dS2;
      next_st.valid = 1'h1;
    end
    case (st.phase)
      qsc_pkg::QSC_PH0: next_st.phase = qsc_pkg::QSC_PH1;
      qsc_pkg::QSC_PH1: next_st.phase = qsc_pkg::QSC_PH2;
      qsc_pkg::QSC_PH2: next_st.phase = qsc_pkg::QSC_PH3;
      qsc_pkg::QSC_PH3: next_st.phase = qsc_pkg::QSC_PH0;
      default:          next_st.phase = qsc_pkg::QSC_PH0;
    endcase
    // Base-rate request stage, loaded once per 1x cycle
    if (st.phase == qsc_pkg::QSC_PH3) begin
      next_st.stage = sysReq;
    end
    // Rising 2x edge: toggle and register the forwarded pair
    if (st.phase == qsc_pkg::QSC_PH0 || st.phase == qsc_pkg::QSC_PH2) begin
      next_st.tff   = ~st.tff;
      next_st.kTrue = st.tff;
      next_st.kComp = ~st.tff;
    end
    // Falling 2x edge: first half carries read side and selects
    if (st.phase == qsc_pkg::QSC_PH1) begin
      next_st.pins.rdSelN = st.stage.rdEn ? qsc_pkg::SEL_ACT
                                          : qsc_pkg::SEL_IDLE;
      next_st.pins.wrSelN = st.stage.wrEn ? qsc_pkg::SEL_ACT
                                          : qsc_pkg::SEL_IDLE;
      next_st.pins.byteSelN = ~st.stage.byteEn;
      next_st.pins.addr   = st.stage.rdAddr;
      next_st.pins.wrData = st.stage.wrWord0;
    end
    // Falling 2x edge: second half carries write address and word
    if (st.phase == qsc_pkg::QSC_PH3) begin
      next_st.pins.addr   = st.stage.wrAddr;
      next_st.pins.wrData = st.stage.wrWord1;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.phase <= qsc_pkg::QSC_PH0;
      st.tff   <= qsc_pkg::RST_TFF;
      st.kTrue <= qsc_pkg::RST_KTRUE;
      st.kComp <= qsc_pkg::RST_KCOMP;
      st.pins.rdSelN <= qsc_pkg::SEL_IDLE;
      st.pins.wrSelN <= qsc_pkg::SEL_IDLE;
      st.pins.byteSelN <= {qsc_pkg::BWS_W{qsc_pkg::SEL_IDLE}};
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  assign memPins = st.pins;
  assign memK    = st.kTrue;
  assign memKn   = st.kComp;
  assign rdWord0 = st.word0;
  assign rdWord1 = st.word1;
  assign rdValid = st.valid;

  // ==========================================================
  // Checks
  logic evenPh;
  assign evenPh = (st.phase == qsc_pkg::QSC_PH0) ||
                  (st.phase == qsc_pkg::QSC_PH2);

  property p_comp;
    @(posedge core_clk) disable iff (!reset_n) memK != memKn;
  endproperty
  a_comp: assert property (p_comp) else $error("pair not complementary");

  property p_kEdge;
    @(posedge core_clk) disable iff (!reset_n)
      $changed(memK) |-> $past(evenPh) && $past(clkEn);
  endproperty
  a_kEdge: assert property (p_kEdge) else $error("clock moved off 2x rise");

  property p_kFromTff;
    @(posedge core_clk) disable iff (!reset_n)
      clkEn && evenPh |=> memK == $past(st.tff) && memKn == ~$past(st.tff);
  endproperty
  a_kFromTff: assert property (p_kFromTff) else $error("pair not from toggle");

  property p_dataEdge;
    @(posedge core_clk) disable iff (!reset_n)
      $changed(memPins) |-> !$past(evenPh);
  endproperty
  a_dataEdge: assert property (p_dataEdge) else $error("data moved on 2x rise");

  property p_take;
    @(posedge core_clk) disable iff (!reset_n)
      clkEn && st.phase == qsc_pkg::QSC_PH3 |=> st.stage == $past(sysReq);
  endproperty
  a_take: assert property (p_take) else $error("request not staged");

  property p_wrSel;
    @(posedge core_clk) disable iff (!reset_n)
      clkEn && st.phase == qsc_pkg::QSC_PH1 && st.stage.wrEn
      |=> !memPins.wrSelN && memPins.wrData == $past(st.stage.wrWord0);
  endproperty
  a_wrSel: assert property (p_wrSel) else $error("write select missing");

  property p_twoWords;
    @(posedge core_clk) disable iff (!reset_n)
      clkEn && st.phase == qsc_pkg::QSC_PH1 ##1 clkEn ##1 clkEn
      |=> memPins.wrData == $past(st.stage.wrWord1)
          && memPins.addr == $past(st.stage.wrAddr);
  endproperty
  a_twoWords: assert property (p_twoWords) else $error("second word missing");

  property p_capLo;
    @(posedge core_clk) disable iff (!reset_n)
      clkEn && st.cS3 && !st.cS2 |=> st.loWord == $past(st.dS2);
  endproperty
  a_capLo: assert property (p_capLo) else $error("fall capture lost");

  property p_capHi;
    @(posedge core_clk) disable iff (!reset_n)
      clkEn && !st.cS3 && st.cS2
      |=> rdValid && rdWord1 == $past(st.dS2) && rdWord0 == $past(st.loWord);
  endproperty
  a_capHi: assert property (p_capHi) else $error("rise capture lost");

  property p_rstK;
    @(posedge core_clk)
      !reset_n ##1 !reset_n
      |-> !memK && memKn && memPins.rdSelN && memPins.wrSelN;
  endproperty
  a_rstK: assert property (p_rstK) else $error("bad reset pair");

  property p_pulse;
    @(posedge core_clk) disable iff (!reset_n)
      rdValid && clkEn |=> !rdValid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("valid held");

  property p_cvRead;
    @(posedge core_clk) disable iff (!reset_n) rdValid;
  endproperty
  c_cvRead: cover property (p_cvRead);

  property p_cvWrite;
    @(posedge core_clk) disable iff (!reset_n) !memPins.wrSelN;
  endproperty
  c_cvWrite: cover property (p_cvWrite);

  property p_cvBoth;
    @(posedge core_clk) disable iff (!reset_n)
      !memPins.wrSelN && !memPins.rdSelN;
  endproperty
  c_cvBoth: cover property (p_cvBoth);

  property p_cvStall;
    @(posedge core_clk) disable iff (!reset_n)
      !clkEn && st.phase == qsc_pkg::QSC_PH3;
  endproperty
  c_cvStall: cover property (p_cvStall);
endmodule // qsc_clock_io

// [verif/qsc_mem_model.sv]
// Behavioural quad-rate memory at the pin side of the controller.
// Assumes memK, memKn and memPins come from the block under test.
`timescale 1ns/100ps
module qsc_mem_model (
  input  wire logic                  memK,
  input  wire logic                  memKn,
  input  wire qsc_pkg::qsc_pins_t    memPins,
  output logic                       retClk,
  output logic [qsc_pkg::DATA_W-1:0] memRdData,
  output qsc_pkg::qsc_pins_t         seenLo,
  output qsc_pkg::qsc_pins_t         seenHi,
  output logic [qsc_pkg::DATA_W-1:0] lastW0,
  output logic [qsc_pkg::DATA_W-1:0] lastW1
);
  logic [qsc_pkg::DATA_W-1:0] heldLo;

  // ==========================================================
  // Pin capture on the forwarded clocks
  always @(posedge memK) seenLo = memPins;
  always @(posedge memKn) seenHi = memPins;

  // ==========================================================
  // Returned clock and read words; each rise publishes the finished pair
  initial begin
    retClk = 1'h0;
    memRdData = '0;
    heldLo = '0;
    lastW0 = '0;
    lastW1 = '0;
    forever begin
      #40 retClk = 1'h1;
      lastW0 = heldLo;
      lastW1 = memRdData;
      #30 memRdData = qsc_pkg::DATA_W'($urandom());
      heldLo = memRdData;
      #10 retClk = 1'h0;
      #30 memRdData = qsc_pkg::DATA_W'($urandom());
      #10;
    end
  end
endmodule // qsc_mem_model

// [verif/tb.sv]
// Self-checking bench for the double-rate pin and clocking block.
// Assumes the memory model drives the returned clock and read data.
`timescale 1ns/100ps
module tb;
  // ==========================================================
  // Signals
  logic                       core_clk;
  logic                       reset_n;
  logic                       clkEn;
  logic                       memK;
  logic                       memKn;
  logic                       retClk;
  logic                       rdValid;
  logic [qsc_pkg::DATA_W-1:0] memRdData;
  logic [qsc_pkg::DATA_W-1:0] rdWord0;
  logic [qsc_pkg::DATA_W-1:0] rdWord1;
  logic [qsc_pkg::DATA_W-1:0] lastW0;
  logic [qsc_pkg::DATA_W-1:0] lastW1;
  qsc_pkg::qsc_req_t          sysReq;
  qsc_pkg::qsc_pins_t         memPins;
  qsc_pkg::qsc_pins_t         seenLo;
  qsc_pkg::qsc_pins_t         seenHi;
  qsc_pkg::qsc_req_t          hist [$];
  int                         bad_count;
  int                         checks;
  int                         nEn;
  int                         nRd;
  int                         nRise;
  int                         nPulse;
  logic                       prevEn;

  qsc_clock_io uut (.core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn),
    .sysReq(sysReq), .memPins(memPins), .memK(memK), .memKn(memKn),
    .retClk(retClk), .memRdData(memRdData), .rdWord0(rdWord0),
    .rdWord1(rdWord1), .rdValid(rdValid));
  qsc_mem_model mem (.memK(memK), .memKn(memKn), .memPins(memPins),
    .retClk(retClk), .memRdData(memRdData), .seenLo(seenLo),
    .seenHi(seenHi), .lastW0(lastW0), .lastW1(lastW1));

  // ==========================================================
  // Helpers
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic qsc_pkg::qsc_pins_t exp_pins(
      input qsc_pkg::qsc_req_t r, input bit hi);
    return {~r.rdEn, ~r.wrEn, ~r.byteEn, hi ? r.wrAddr : r.rdAddr,
            hi ? r.wrWord1 : r.wrWord0};
  endfunction

  // Waits for an enabled edge; clkEn never stays low two edges
  task automatic en_edge();
    logic e;
    do begin
      @(posedge core_clk);
      e = clkEn;
      clkEn <= e ? ($urandom() % 5 != 0) : 1'h1;
    end while (!e);
    if (nEn > 0) check(memK, (nEn - 1) % 4 >= 2);
    if (nEn > 0) check(memKn, (nEn - 1) % 4 < 2);
    nEn++;
  endtask

  task automatic do_reset();
    reset_n <= 1'h0;
    @(posedge core_clk);
    clkEn <= 1'h1;
    repeat (5) @(posedge core_clk);
    check(memK, 1'h0);
    check(memKn, 1'h1);
    check(memPins, {4'hf, 36'h0});
    reset_n <= 1'h1;
    nEn = 0;
    nRd = 0;
    nRise = 0;
    hist.delete();
  endtask

  task automatic run(input int n);
    qsc_pkg::qsc_req_t r;
    logic [95:0]       x;
    for (int i = 0; i < n; i++) begin
      x = {$urandom(), $urandom(), $urandom()};
      r = x[75:0];
      if (i == 0) r = '1;
      if (i == 1) r = '0;
      sysReq <= r;
      hist.push_back(r);
      repeat (2) en_edge();
      if (i >= 2) check(seenLo, exp_pins(hist[i-2], 1'b0));
      if (i >= 2) check(seenHi, exp_pins(hist[i-2], 1'b1));
      repeat (2) en_edge();
    end
    $display("Run of %0d requests done, mismatches %0d", n, bad_count);
  endtask

  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // Read pairs against the words the model launched
  always @(posedge core_clk) begin
    if (rdValid === 1'h1 && prevEn === 1'h1) begin
      nRd++;
      nPulse++;
      if (nRd > 1) check(rdWord0, lastW0);
      if (nRd > 1) check(rdWord1, lastW1);
    end
    prevEn = clkEn;
  end

  // One read pair per returned clock rise
  always @(posedge retClk) begin
    if (nRise > 0 && reset_n === 1'h1) check(nPulse, 1);
    nRise++;
    nPulse = 0;
  end

  always #2.5 core_clk = ~core_clk;

  initial begin
    #60000;
    bad_count++;
    final_report();
  end

  initial begin
    core_clk = 1'h0;
    clkEn = 1'h1;
    prevEn = 1'h0;
    nRise = 0;
    nPulse = 0;
    sysReq = '0;
    bad_count = 0;
    checks = 0;
    nEn = 0;
    nRd = 0;
    void'($urandom(32'h81f6e26b));
    do_reset();
    run(120);
    do_reset();
    run(60);
    final_report();
  end
endmodule // tb
